// file: hw/simd_string_datapath.sv
`timescale 1ns/1ps
`default_nettype none

module simd_string_datapath
	import simd_string_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	input  wire logic               req_valid,
	input  wire op_t                op,
	input  wire logic [VEC_W-1:0]   src_dst,
	input  wire logic [VEC_W-1:0]   src_b,
	input  wire logic [7:0]         imm,
	input  wire logic [31:0]        length_reg_first,
	input  wire logic [31:0]        length_reg_second,
	input  wire logic               mem_access,
	input  wire logic [3:0]         mem_addr_low,
	input  wire logic               align_check_en,
	output logic                    res_valid,
	output logic [VEC_W-1:0]        res_vec,
	output logic                    res_vec_we,
	output logic                    res_to_reg_zero,
	output logic [CNT_W-1:0]        count_gp_reg,
	output logic                    count_we,
	output logic                    zero_cond_flag,
	output logic                    carry_cond_flag,
	output logic                    flags_we,
	output logic                    align_fault
);

	typedef struct packed {
		logic             valid;
		logic [VEC_W-1:0] vec;
		logic             vec_we;
		logic             to_zero;
		logic [CNT_W-1:0] count;
		logic             count_we;
		logic             zf;
		logic             cf;
		logic             flags_we;
		logic             fault;
	} state_t;

	state_t state_q;
	state_t state_d;

	// One string element, widened to 17 signed bits so signed and unsigned compare alike.
	function automatic logic signed [16:0] elem(logic [VEC_W-1:0] v, int i, logic w, logic s);
		logic [15:0] r;
		r = w ? v[i*16 +: 16] : {8'h00, v[i*8 +: 8]};
		elem = w ? {s & r[15], r} : {{9{s & r[7]}}, r[7:0]};
	endfunction

	// Widen from sb source bytes to db destination bytes per lane.
	function automatic logic [VEC_W-1:0] widen(logic [VEC_W-1:0] v, int sb, int db, logic s);
		logic [VEC_W-1:0] r;
		int e;
		int k;
		r = '0;
		for (int p = 0; p < VEC_BYTES; p++) begin
			e = p / db;
			k = p % db;
			if (k < sb)
				r[p*8 +: 8] = v[(e*sb+k)*8 +: 8];
			else
				r[p*8 +: 8] = {8{s & v[(e*sb+sb)*8-1]}};
		end
		widen = r;
	endfunction

	// Valid-element mask from an explicit length or a null terminator.
	function automatic logic [15:0] valid_mask(logic [VEC_W-1:0] v, logic [31:0] l,
			logic expl, logic w);
		logic [15:0] m;
		logic [31:0] a;
		logic        seen;
		int          n;
		m = '0;
		seen = 1'b0;
		n = w ? WORD_LANES : VEC_BYTES;
		a = l[31] ? 32'h0 - l : l;
		for (int i = 0; i < VEC_BYTES; i++) begin
			if (expl)
				m[i] = (i < n) && (a > 32'(i));
			else begin
				if (i < n && elem(v, i, w, 1'b0) == 17'sh0)
					seen = 1'b1;
				m[i] = (i < n) && !seen;
			end
		end
		valid_mask = m;
	endfunction

	// Pairwise compare matrix, aggregation and polarity of the string family.
	function automatic logic [15:0] str_agg(logic [VEC_W-1:0] a, logic [VEC_W-1:0] b,
			logic [15:0] va, logic [15:0] vb, logic [7:0] im);
		logic [15:0] r;
		logic        w;
		logic        s;
		int          n;
		r = '0;
		w = im[IMM_WORD_BIT];
		s = im[IMM_SIGNED_BIT];
		n = w ? WORD_LANES : VEC_BYTES;
		for (int j = 0; j < VEC_BYTES; j++) begin
			if (j < n) begin
				unique case (im[IMM_MODE_LO +: 2])
					MODE_EQ_ANY: begin
						for (int i = 0; i < VEC_BYTES; i++)
							if (i < n && va[i] && vb[j] && elem(a, i, w, s) == elem(b, j, w, s))
								r[j] = 1'b1;
					end
					MODE_RANGES: begin
						for (int i = 0; i < VEC_BYTES; i += 2)
							if (i < n && va[i] && va[i+1] && vb[j]
									&& elem(a, i, w, s) <= elem(b, j, w, s)
									&& elem(a, i+1, w, s) >= elem(b, j, w, s))
								r[j] = 1'b1;
					end
					MODE_EQ_EACH: begin
						r[j] = (va[j] && vb[j]) ? elem(a, j, w, s) == elem(b, j, w, s)
								: !(va[j] || vb[j]);
					end
					MODE_EQ_ORDERED: begin
						r[j] = 1'b1;
						for (int k = 0; k < VEC_BYTES; k++)
							if (k < n - j && va[k]
									&& !(vb[j+k] && elem(a, k, w, s) == elem(b, j+k, w, s)))
								r[j] = 1'b0;
					end
				endcase
				if (im[IMM_POL_LO +: 2] == POL_NEG_ALL
						|| (im[IMM_POL_LO +: 2] == POL_NEG_VALID && vb[j]))
					r[j] = !r[j];
			end
		end
		str_agg = r;
	endfunction

	// Saturate one signed dword into the unsigned word range.
	function automatic logic [15:0] sat_uw(logic signed [31:0] d);
		if (d < 0)
			sat_uw = 16'h0000;
		else if (d > UWORD_MAX)
			sat_uw = 16'hffff;
		else
			sat_uw = d[15:0];
	endfunction

	// The whole result is formed in one cycle and registered; issue sees it one edge later.
	always_comb begin
		logic [15:0] va;
		logic [15:0] vb;
		logic [15:0] r2;
		logic [15:0] minv;
		logic [2:0]  mini;
		logic [15:0] sum;
		logic        wd;
		logic        expl;
		int          sb;
		int          db;
		int          n;
		va = '0;
		vb = '0;
		r2 = '0;
		minv = 16'hffff;
		mini = 3'h0;
		sum = '0;
		wd = imm[IMM_WORD_BIT];
		expl = (op == explicit_len_string_index) || (op == explicit_len_string_mask);
		sb = 1;
		db = 2;
		n = wd ? WORD_LANES : VEC_BYTES;
		state_d = '0;
		state_d.valid = req_valid;
		if (req_valid) begin
			unique case (op)
				widen_signed_byte_to_word, widen_unsigned_byte_to_word,
				widen_signed_byte_to_dword, widen_unsigned_byte_to_dword,
				widen_signed_word_to_dword, widen_unsigned_word_to_dword,
				widen_signed_byte_to_qword, widen_unsigned_byte_to_qword,
				widen_signed_word_to_qword, widen_unsigned_word_to_qword,
				widen_signed_dword_to_qword, widen_unsigned_dword_to_qword: begin
					unique case (op)
						widen_signed_byte_to_word, widen_unsigned_byte_to_word: begin
							sb = 1;
							db = 2;
						end
						widen_signed_byte_to_dword, widen_unsigned_byte_to_dword: begin
							sb = 1;
							db = 4;
						end
						widen_signed_word_to_dword, widen_unsigned_word_to_dword: begin
							sb = 2;
							db = 4;
						end
						widen_signed_byte_to_qword, widen_unsigned_byte_to_qword: begin
							sb = 1;
							db = 8;
						end
						widen_signed_word_to_qword, widen_unsigned_word_to_qword: begin
							sb = 2;
							db = 8;
						end
						default: begin
							sb = 4;
							db = 8;
						end
					endcase
					// Signed variants take the even positions of the enumeration.
					state_d.vec = widen(src_b, sb, db, !op[0]);
					// Memory width is element count times source width, a power of two.
					state_d.fault = mem_access && align_check_en
							&& ((32'(mem_addr_low) & (VEC_BYTES / db * sb - 1)) != 0);
				end
				multi_abs_diff_sum: begin
					for (int j = 0; j < WORD_LANES; j++) begin
						sum = '0;
						for (int k = 0; k < 4; k++) begin
							sum = sum + 16'(elem(src_dst, 4*imm[IMM_DOFF_BIT] + j + k, 1'b0, 1'b0)
									- elem(src_b, 4*imm[IMM_REF_LO +: 2] + k, 1'b0, 1'b0) < 0
									? elem(src_b, 4*imm[IMM_REF_LO +: 2] + k, 1'b0, 1'b0)
									- elem(src_dst, 4*imm[IMM_DOFF_BIT] + j + k, 1'b0, 1'b0)
									: elem(src_dst, 4*imm[IMM_DOFF_BIT] + j + k, 1'b0, 1'b0)
									- elem(src_b, 4*imm[IMM_REF_LO +: 2] + k, 1'b0, 1'b0));
						end
						state_d.vec[j*16 +: 16] = sum;
					end
				end
				horizontal_min_search: begin
					// Strict compare keeps the lowest lane on a tie.
					for (int i = 0; i < WORD_LANES; i++)
						if (src_b[i*16 +: 16] < minv || i == 0) begin
							minv = src_b[i*16 +: 16];
							mini = 3'(i);
						end
					state_d.vec[15:0] = minv;
					state_d.vec[MIN_IDX_LO +: 3] = mini;
				end
				packed_bit_test: begin
					state_d.zf = (src_dst & src_b) == '0;
					state_d.cf = (src_dst & ~src_b) == '0;
					state_d.flags_we = 1'b1;
				end
				quad_equal_compare, quad_greater_compare: begin
					for (int q = 0; q < 2; q++)
						state_d.vec[q*64 +: 64] = {64{op == quad_equal_compare
								? src_dst[q*64 +: 64] == src_b[q*64 +: 64]
								: $signed(src_dst[q*64 +: 64]) > $signed(src_b[q*64 +: 64])}};
				end
				dword_to_word_unsigned_pack: begin
					for (int i = 0; i < 4; i++) begin
						state_d.vec[i*16 +: 16] = sat_uw(src_dst[i*32 +: 32]);
						state_d.vec[64 + i*16 +: 16] = sat_uw(src_b[i*32 +: 32]);
					end
				end
				default: begin
					// String family: alignment is never checked here.
					va = valid_mask(src_dst, length_reg_first, expl, wd);
					vb = valid_mask(src_b, length_reg_second, expl, wd);
					r2 = str_agg(src_dst, src_b, va, vb, imm);
					state_d.cf = r2 != '0;
					state_d.zf = vb != (wd ? 16'h00ff : 16'hffff);
					state_d.flags_we = 1'b1;
					if (op == explicit_len_string_index || op == implicit_len_string_index) begin
						state_d.count = CNT_W'(n);
						for (int j = 0; j < VEC_BYTES; j++)
							if (j < n && r2[j] && (imm[IMM_OUT_BIT] || state_d.count == CNT_W'(n)))
								state_d.count = CNT_W'(j);
						state_d.count_we = 1'b1;
					end else begin
						for (int j = 0; j < VEC_BYTES; j++)
							if (imm[IMM_OUT_BIT])
								state_d.vec[j*8 +: 8] = {8{r2[wd ? j/2 : j]}};
							else
								state_d.vec[j] = r2[j];
						state_d.to_zero = 1'b1;
					end
				end
			endcase
			state_d.vec_we = !state_d.fault && op != packed_bit_test && !state_d.count_we;
			if (state_d.fault)
				state_d.flags_we = 1'b0;
		end
	end

	// Reset clears every result so nothing is written before the first request.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign res_valid       = state_q.valid;
	assign res_vec         = state_q.vec;
	assign res_vec_we      = state_q.vec_we;
	assign res_to_reg_zero = state_q.to_zero;
	assign count_gp_reg    = state_q.count;
	assign count_we        = state_q.count_we;
	assign zero_cond_flag  = state_q.zf;
	assign carry_cond_flag = state_q.cf;
	assign flags_we        = state_q.flags_we;
	assign align_fault     = state_q.fault;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_req(op_t o);
		req_valid && op == o;
	endsequence

	sequence s_string;
		req_valid && op >= explicit_len_string_index && op <= implicit_len_string_mask;
	endsequence

	a_widen_sign_bw: assert property (s_req(widen_signed_byte_to_word) |=>
		res_vec[31:16] == {{8{$past(src_b[15])}}, $past(src_b[15:8])})
		else $error("byte to word sign extension wrong");
	a_widen_zero_dq: assert property (s_req(widen_unsigned_dword_to_qword) |=>
		res_vec[127:64] == {32'h0, $past(src_b[63:32])})
		else $error("dword to qword zero extension wrong");
	a_widen_align_fault: assert property (s_req(widen_signed_word_to_dword) ##0 (mem_access
		&& align_check_en && mem_addr_low[2:0] != 3'h0) |=> align_fault && !res_vec_we)
		else $error("misaligned widen not faulted");
	a_sad_first_sum: assert property (s_req(multi_abs_diff_sum) ##0 (imm[2:0] == 3'h0
		&& src_dst[31:0] == src_b[31:0]) |=> res_vec[15:0] == 16'h0)
		else $error("equal groups give nonzero sum");
	a_min_index_range: assert property (s_req(horizontal_min_search) |=>
		res_vec[127:19] == '0 && res_vec[15:0] <= $past(src_b[15:0]))
		else $error("minimum result malformed");
	a_packed_bit_test_zero: assert property (s_req(packed_bit_test) |=>
		zero_cond_flag == (($past(src_dst) & $past(src_b)) == '0) && flags_we)
		else $error("zero flag wrong");
	a_packed_bit_test_carry: assert property (s_req(packed_bit_test) |=>
		carry_cond_flag == (($past(src_dst) & ~$past(src_b)) == '0) && !res_vec_we)
		else $error("carry flag wrong or destination written");
	a_quad_eq_lane: assert property (s_req(quad_equal_compare) |=>
		res_vec[63:0] == {64{$past(src_dst[63:0]) == $past(src_b[63:0])}})
		else $error("quad equal lane wrong");
	a_quad_gt_lane: assert property (s_req(quad_greater_compare) |=>
		res_vec[127:64] == {64{$signed($past(src_dst[127:64])) > $signed($past(src_b[127:64]))}})
		else $error("quad greater lane wrong");
	a_pack_negative: assert property (s_req(dword_to_word_unsigned_pack) ##0 src_dst[31]
		|=> res_vec[15:0] == 16'h0)
		else $error("negative dword not clamped");
	a_string_no_fault: assert property (s_string ##1 1'b1 |-> !align_fault && flags_we)
		else $error("string compare faulted");
	a_index_bound: assert property (s_string ##0 !op[0] |=> count_we
		&& count_gp_reg <= 5'h10 && !res_vec_we)
		else $error("index result out of range");

endmodule

`default_nettype wire

// file: hw/simd_string_pkg.sv
package simd_string_pkg;

	// Vector and lane geometry.
	localparam int VEC_W      = 128;
	localparam int VEC_BYTES  = 16;
	localparam int WORD_LANES = 8;
	localparam int CNT_W      = 5;

	// Immediate field positions for the string compare family.
	localparam int IMM_WORD_BIT   = 0;
	localparam int IMM_SIGNED_BIT = 1;
	localparam int IMM_MODE_LO    = 2;
	localparam int IMM_POL_LO     = 4;
	localparam int IMM_OUT_BIT    = 6;

	// Immediate field positions for the multiple absolute difference sum.
	localparam int IMM_REF_LO  = 0;
	localparam int IMM_DOFF_BIT = 2;

	// String compare modes and polarity codes.
	localparam logic [1:0] MODE_EQ_ANY     = 2'h0;
	localparam logic [1:0] MODE_RANGES     = 2'h1;
	localparam logic [1:0] MODE_EQ_EACH    = 2'h2;
	localparam logic [1:0] MODE_EQ_ORDERED = 2'h3;
	localparam logic [1:0] POL_NEG_ALL     = 2'h1;
	localparam logic [1:0] POL_NEG_VALID   = 2'h3;

	// Position of the lane index beside the minimum value.
	localparam int MIN_IDX_LO = 16;

	// Largest value of an unsigned word lane.
	localparam logic signed [31:0] UWORD_MAX = 32'sh0000ffff;

	// Operation select from instruction issue.
	typedef enum logic [4:0] {
		widen_signed_byte_to_word,
		widen_unsigned_byte_to_word,
		widen_signed_byte_to_dword,
		widen_unsigned_byte_to_dword,
		widen_signed_word_to_dword,
		widen_unsigned_word_to_dword,
		widen_signed_byte_to_qword,
		widen_unsigned_byte_to_qword,
		widen_signed_word_to_qword,
		widen_unsigned_word_to_qword,
		widen_signed_dword_to_qword,
		widen_unsigned_dword_to_qword,
		multi_abs_diff_sum,
		horizontal_min_search,
		packed_bit_test,
		quad_equal_compare,
		quad_greater_compare,
		dword_to_word_unsigned_pack,
		explicit_len_string_index,
		explicit_len_string_mask,
		implicit_len_string_index,
		implicit_len_string_mask
	} op_t;

endpackage

// file: verif/issue_regfile_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stands in for instruction issue and the register file around the datapath.
module issue_regfile_model
	import simd_string_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	output op_t                   op,
	output logic                  req_valid,
	output logic [VEC_W-1:0]      src_dst,
	output logic [VEC_W-1:0]      src_b,
	output logic [7:0]            imm,
	output logic [31:0]           length_reg_first,
	output logic [31:0]           length_reg_second,
	output logic                  mem_access,
	output logic [3:0]            mem_addr_low,
	output logic                  align_check_en,
	input  wire logic             res_valid,
	input  wire logic [VEC_W-1:0] res_vec,
	input  wire logic             res_vec_we,
	input  wire logic             res_to_reg_zero,
	output logic [VEC_W-1:0]      dst_reg,
	output logic [VEC_W-1:0]      zero_reg
);
	// Presents one request; callers enter just after a rising edge.
	task automatic issue(input logic v, input op_t o, input logic [VEC_W-1:0] a,
			input logic [VEC_W-1:0] b, input logic [7:0] i, input logic [31:0] la,
			input logic [31:0] lb, input logic m, input logic [3:0] ad, input logic ck);
		req_valid = v;
		op = o;
		src_dst = a;
		src_b = b;
		imm = i;
		length_reg_first = la;
		length_reg_second = lb;
		mem_access = m;
		mem_addr_low = ad;
		align_check_en = ck;
	endtask

	// After the last request the operand buses flip, so a stale value is never mistaken for live data.
	task automatic idle();
		req_valid = 1'b0;
		src_dst = ~src_dst;
		src_b = ~src_b;
		length_reg_first = ~length_reg_first;
		length_reg_second = ~length_reg_second;
	endtask

	// Quiet inputs from time zero.
	initial begin
		issue(1'b0, packed_bit_test, '0, '0, 8'h00, 32'h0, 32'h0, 1'b0, 4'h0, 1'b0);
	end

	// Register file: results land only when the write enable says so.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dst_reg <= '0;
			zero_reg <= '0;
		end else if (res_valid && res_vec_we) begin
			if (res_to_reg_zero) begin
				zero_reg <= res_vec;
			end else begin
				dst_reg <= res_vec;
			end
		end
	end
endmodule

`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import simd_string_pkg::*;
	logic                 core_clk;
	logic                 rst_n;
	op_t                  op;
	logic                 req_valid, mem_access, align_check_en;
	logic [VEC_W-1:0]     src_dst, src_b, res_vec, e_vec;
	logic [7:0]           imm;
	logic [31:0]          length_reg_first, length_reg_second, seed;
	logic [3:0]           mem_addr_low;
	logic                 res_valid, res_vec_we, res_to_reg_zero, count_we;
	logic                 zero_cond_flag, carry_cond_flag, flags_we, align_fault;
	logic [CNT_W-1:0]     count_gp_reg, e_cnt;
	logic                 e_vwe, e_z0, e_cwe, e_zf, e_cf, e_fwe, e_flt;
	int                   fail_count, checks, cyc;

	simd_string_datapath uut (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
		.op(op), .src_dst(src_dst), .src_b(src_b), .imm(imm),
		.length_reg_first(length_reg_first), .length_reg_second(length_reg_second),
		.mem_access(mem_access), .mem_addr_low(mem_addr_low), .align_check_en(align_check_en),
		.res_valid(res_valid), .res_vec(res_vec), .res_vec_we(res_vec_we),
		.res_to_reg_zero(res_to_reg_zero), .count_gp_reg(count_gp_reg), .count_we(count_we),
		.zero_cond_flag(zero_cond_flag), .carry_cond_flag(carry_cond_flag),
		.flags_we(flags_we), .align_fault(align_fault));

	issue_regfile_model partner (.core_clk(core_clk), .rst_n(rst_n), .op(op),
		.req_valid(req_valid), .src_dst(src_dst), .src_b(src_b), .imm(imm),
		.length_reg_first(length_reg_first), .length_reg_second(length_reg_second),
		.mem_access(mem_access), .mem_addr_low(mem_addr_low), .align_check_en(align_check_en),
		.res_valid(res_valid), .res_vec(res_vec), .res_vec_we(res_vec_we),
		.res_to_reg_zero(res_to_reg_zero), .dst_reg(), .zero_reg());

	// 50 MHz clock.
	initial core_clk = 1'b0;
	always #10 core_clk = ~core_clk;

	// Xorshift keeps the random run repeatable.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// One string element of a fragment, sign- or zero-extended as the immediate asks.
	function automatic int el(logic [VEC_W-1:0] v, int i, int ew, logic s);
		logic [15:0] r;
		r = 16'(v >> (i * ew));
		if (ew == 8)
			return s ? int'($signed(r[7:0])) : int'(r[7:0]);
		return s ? int'($signed(r)) : int'(r);
	endfunction

	// Works out every output from the current request inputs.
	task automatic predict();
		int sw_t[6] = '{8, 8, 16, 8, 16, 32};
		int dw_t[6] = '{16, 32, 32, 64, 64, 64};
		int k, sw, dw, n, i, j, s, na, nb, ne, ew;
		logic [63:0] x, sm, dm;
		logic [15:0] mk, vb;
		logic signed [31:0] d;
		logic sg;
		e_vec = '0; e_vwe = 1'b1; e_z0 = 1'b0; e_cnt = '0; e_cwe = 1'b0;
		e_zf = 1'b0; e_cf = 1'b0; e_fwe = 1'b0; e_flt = 1'b0;
		k = int'(op);
		if (k < 12) begin
			sw = sw_t[k / 2];
			dw = dw_t[k / 2];
			n = 128 / dw;
			sm = (64'h1 << sw) - 64'h1;
			dm = (64'h1 << dw) - 64'h1;
			for (i = 0; i < n; i++) begin
				x = 64'(src_b >> (i * sw)) & sm;
				if (k % 2 == 0 && x[sw - 1]) x |= ~sm;
				e_vec |= VEC_W'(x & dm) << (i * dw);
			end
			e_flt = mem_access && align_check_en && (int'(mem_addr_low) % (n * sw / 8) != 0);
			e_vwe = !e_flt;
			return;
		end
		case (op)
			multi_abs_diff_sum: for (j = 0; j < 8; j++) begin
				s = 0;
				for (i = 0; i < 4; i++) begin
					d = int'(src_dst[(imm[2] * 4 + j + i) * 8 +: 8])
						- int'(src_b[(imm[1:0] * 4 + i) * 8 +: 8]);
					s += (d < 0) ? -d : d;
				end
				e_vec[j * 16 +: 16] = 16'(s);
			end
			horizontal_min_search: begin
				e_vec[15:0] = src_b[15:0];
				for (i = 1; i < 8; i++) if (src_b[i * 16 +: 16] < e_vec[15:0]) begin
					e_vec[15:0] = src_b[i * 16 +: 16];
					e_vec[18:16] = 3'(i);
				end
			end
			packed_bit_test: begin
				e_vwe = 1'b0; e_fwe = 1'b1;
				e_zf = ((src_dst & src_b) == '0);
				e_cf = ((~src_b & src_dst) == '0);
			end
			quad_equal_compare, quad_greater_compare: for (i = 0; i < 2; i++)
				e_vec[i * 64 +: 64] = ((op == quad_equal_compare)
					? (src_dst[i * 64 +: 64] == src_b[i * 64 +: 64])
					: ($signed(src_dst[i * 64 +: 64]) > $signed(src_b[i * 64 +: 64]))) ? '1 : '0;
			dword_to_word_unsigned_pack: for (i = 0; i < 8; i++) begin
				d = (i < 4) ? src_dst[i * 32 +: 32] : src_b[(i - 4) * 32 +: 32];
				e_vec[i * 16 +: 16] = (d < 0) ? 16'h0000 : (d > UWORD_MAX) ? 16'hffff : d[15:0];
			end
			default: begin
				ew = imm[0] ? 16 : 8;
				ne = 128 / ew;
				na = ne;
				nb = ne;
				sg = imm[1];
				if (op == explicit_len_string_index || op == explicit_len_string_mask) begin
					na = int'(length_reg_first);
					nb = int'(length_reg_second);
					na = na < 0 ? -na : na;
					nb = nb < 0 ? -nb : nb;
					na = na > ne ? ne : na;
					nb = nb > ne ? ne : nb;
				end else for (i = ne - 1; i >= 0; i--) begin
					if (el(src_dst, i, ew, 1'b0) == 0) na = i;
					if (el(src_b, i, ew, 1'b0) == 0) nb = i;
				end
				mk = '0;
				vb = '0;
				// Valid elements form a prefix, so validity is just an index below the count.
				for (j = 0; j < ne; j++) begin
					vb[j] = j < nb;
					case (imm[3:2])
						MODE_EQ_ANY: for (i = 0; i < na; i++)
							mk[j] |= vb[j] && el(src_dst, i, ew, sg) == el(src_b, j, ew, sg);
						MODE_RANGES: for (i = 0; i + 1 < na; i += 2)
							mk[j] |= vb[j] && el(src_dst, i, ew, sg) <= el(src_b, j, ew, sg)
								&& el(src_dst, i + 1, ew, sg) >= el(src_b, j, ew, sg);
						MODE_EQ_EACH: mk[j] = (j < na && vb[j])
							? el(src_dst, j, ew, sg) == el(src_b, j, ew, sg) : (j >= na && !vb[j]);
						default: begin
							mk[j] = 1'b1;
							for (i = 0; i < na && i < ne - j; i++)
								if (j + i >= nb || el(src_dst, i, ew, sg) != el(src_b, j + i, ew, sg))
									mk[j] = 1'b0;
						end
					endcase
				end
				if (imm[5:4] == POL_NEG_ALL) mk = ~mk;
				if (imm[5:4] == POL_NEG_VALID) mk ^= vb;
				mk &= (ne == 16) ? 16'hffff : 16'h00ff;
				e_fwe = 1'b1; e_cf = |mk; e_zf = (nb < ne);
				if (op == explicit_len_string_index || op == implicit_len_string_index) begin
					e_vwe = 1'b0; e_cwe = 1'b1; e_cnt = CNT_W'(ne);
					for (i = 0; i < ne; i++) if (mk[i] && (imm[6] || e_cnt == ne)) e_cnt = CNT_W'(i);
				end else begin
					e_z0 = 1'b1;
					if (!imm[6]) e_vec[15:0] = mk;
					else for (j = 0; j < ne; j++) e_vec[j * ew +: 16] = mk[j] ? (ew == 16 ? 16'hffff : 16'h00ff) : 16'h0;
				end
			end
		endcase
	endtask

	// One request presented after an edge, judged just after the edge that takes it.
	task automatic run(input op_t o, input logic [VEC_W-1:0] a, input logic [VEC_W-1:0] b,
			input logic [7:0] i, input logic [31:0] la, input logic [31:0] lb,
			input logic m, input logic [3:0] ad, input logic ck);
		partner.issue(1'b1, o, a, b, i, la, lb, m, ad, ck);
		@(posedge core_clk);
		// The request still stands at the taking edge, and the port copies have settled by now.
		predict();
		#1;
		checks++;
		if (res_valid !== 1'b1 || res_vec_we !== e_vwe || flags_we !== e_fwe || count_we !== e_cwe
				|| res_to_reg_zero !== e_z0 || align_fault !== e_flt || (e_vwe && res_vec !== e_vec)
				|| (e_fwe && (zero_cond_flag !== e_zf || carry_cond_flag !== e_cf))
				|| (e_cwe && count_gp_reg !== e_cnt)) begin
			fail_count++;
			$display("mismatch at %0t: result of %s differs", $time, o.name());
		end
	endtask

	// Random operands; string data from a tiny alphabet so matches and nulls occur.
	// The alphabet keeps the top bit so signed and unsigned ranges differ.
	task automatic rand_op();
		op_t o;
		logic [VEC_W-1:0] a, b;
		o = op_t'(5'(rnd() % 22));
		a = {rnd(), rnd(), rnd(), rnd()};
		b = {rnd(), rnd(), rnd(), rnd()};
		if (int'(o) >= int'(explicit_len_string_index)) begin
			a &= {16{8'h83}};
			b &= {16{8'h83}};
		end
		run(o, a, b, 8'(rnd()), 32'(int'(rnd() % 41) - 20), 32'(int'(rnd() % 41) - 20),
			rnd() % 2, 4'(rnd()), rnd() % 2);
	endtask

	// Closing report and verdict.
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Cuts a hang short well above the few hundred cycles the run needs.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			$display("mismatch at %0t: run did not finish", $time);
			wrap_up();
		end
	end

	// Reset, hand-written corners, then back-to-back random traffic.
	initial begin
		seed = 32'd82238;
		rst_n = 1'b0;
		repeat (20) @(posedge core_clk);
		#1 rst_n = 1'b1;
		@(posedge core_clk);
		#1;
		run(packed_bit_test, '0, '1, 8'h00, 0, 0, 1'b1, 4'h1, 1'b1);
		run(packed_bit_test, {4{32'h00f0_0f00}}, {4{32'h00ff_0ff0}}, 8'h00, 0, 0, 1'b0, 4'h0, 1'b0);
		run(dword_to_word_unsigned_pack, {32'hffffffff, 32'h0000ffff, 32'h00010000, 32'h7fffffff},
			{32'h80000000, 32'h0, 32'h0000fffe, 32'h00000001}, 8'h00, 0, 0, 1'b0, 4'h0, 1'b0);
		run(widen_signed_word_to_dword, '0, {8{16'h8001}}, 8'h00, 0, 0, 1'b1, 4'h4, 1'b1);
		run(widen_unsigned_byte_to_qword, '0, {16{8'h80}}, 8'h00, 0, 0, 1'b1, 4'h2, 1'b1);
		run(horizontal_min_search, '0, {8{16'h0005}}, 8'h00, 0, 0, 1'b0, 4'h0, 1'b0);
		run(multi_abs_diff_sum, {4{32'h80ff_017f}}, {4{32'h80ff_017f}}, 8'h00, 0, 0,
			1'b0, 4'h0, 1'b0);
		run(multi_abs_diff_sum, {4{32'h10ff_027e}}, {4{32'h0133_fe00}}, 8'h07, 0, 0,
			1'b0, 4'h0, 1'b0);
		run(explicit_len_string_index, {16{8'h01}}, {16{8'h01}}, 8'h00, 32'hfffffffd, 0, 1'b1, 4'h3, 1'b1);
		run(explicit_len_string_mask, {16{8'h02}}, {16{8'h02}}, 8'h41, 32'd40, 32'hffffffec, 1'b0, 4'h0, 1'b0);
		run(implicit_len_string_index, {8{16'h0302}}, {8'h00, {15{8'h03}}}, 8'h70, 0, 0, 1'b0, 4'h0, 1'b0);
		repeat (400) rand_op();
		partner.idle();
		@(posedge core_clk);
		#1;
		checks++;
		if (res_valid !== 1'b0 || res_vec_we !== 1'b0 || flags_we !== 1'b0 || count_we !== 1'b0) begin
			fail_count++;
			$display("mismatch at %0t: outputs did not return to idle", $time);
		end
		wrap_up();
	end
endmodule

`default_nettype wire
